/* insn_exec_params.svh */
// offsets, opcodes, field positions, reset values and timing counts for the
// branch, call, return and timer instruction executor.
// assumes a 10-bit instruction word and a single page of program memory.
`ifndef INSN_EXEC_PARAMS_SVH
`define INSN_EXEC_PARAMS_SVH

// instruction, address, nibble, timer and interval widths
`define INSN_W              10
`define ADDR_W              10
`define NIB_W               4
`define TIMER_W             10
`define INTERVAL_W          18

// program space: one page, 000H to 3FFH
`define PAGE_FIRST          10'h000
`define PAGE_LAST           10'h3FF
`define PC_STEP_TWO_WORD    10'h002

// first-word opcodes, page 0
`define OP_JUMP_CARRY       10'h191
`define OP_JUMP_NO_CARRY    10'h1B1
`define OP_JUMP_FLAG        10'h1D1
`define OP_JUMP_NO_FLAG     10'h1F1
`define OP_CALL             10'h141
`define OP_RET              10'h124
`define OP_TIMER_RD_LOW     10'h3DF
`define OP_TIMER_RD_HIGH    10'h3FF
`define OP_TIMER_WR_LOW     10'h09F
`define OP_TIMER_WR_HIGH    10'h0BF
`define OP_TIMER_LOAD_IMM   10'h0DF

// timer bit positions of each nibble
`define TIMER_HIGH_MSB      9
`define TIMER_HIGH_LSB      6
`define TIMER_LOW_MSB       5
`define TIMER_LOW_LSB       2
`define TIMER_HIGH_CLR_BIT  1
`define TIMER_LOW_CLR_BIT   0

// reset values
`define STACK_PTR_RESET     0
`define RET_ADDR_RESET      10'h000
`define TIMER_RESET         10'h000

// timer interval: (value + 1) x 64 or 128 oscillator periods
`define TIMER_SCALE_FAST    18'h0_0040
`define TIMER_SCALE_SLOW    18'h0_0080

`endif

/* insn_exec_pkg.sv */
// types shared by the instruction executor and its decoder.
// assumes insn_exec_params.svh is on the include path.
`default_nettype none

package insn_exec_pkg;

	typedef enum logic [3:0] {
		INSN_NONE,
		INSN_JUMP_CARRY,
		INSN_JUMP_NO_CARRY,
		INSN_JUMP_FLAG,
		INSN_JUMP_NO_FLAG,
		INSN_CALL,
		INSN_RET,
		INSN_TIMER_RD_LOW,
		INSN_TIMER_RD_HIGH,
		INSN_TIMER_WR_LOW,
		INSN_TIMER_WR_HIGH,
		INSN_TIMER_LOAD_IMM
	} insn_class_t;

endpackage : insn_exec_pkg

`default_nettype wire

/* insn_decoder.sv */
// combinational decoder: classifies the first word and unscrambles the
// address and timer fields of the second word.
// assumes both words are presented together and stable for the cycle.
`include "insn_exec_params.svh"
`default_nettype none

module insn_decoder
	import insn_exec_pkg::*;
(
	input  wire logic [`INSN_W-1:0]  opcode_word,   // first word
	input  wire logic [`INSN_W-1:0]  operand_word,  // second word
	output var insn_class_t          insn_class,    // decoded class
	output logic      [`ADDR_W-1:0]  target_addr,   // unscrambled address
	output logic      [`TIMER_W-1:0] timer_imm      // unscrambled timer data
);

	// second word, msb first: a9 a7 a6 a5 a4 a8 a3 a2 a1 a0
	function automatic logic [`ADDR_W-1:0] unscramble_addr(input logic [`INSN_W-1:0] w);
		unscramble_addr = {w[9], w[4], w[8:5], w[3:0]};
	endfunction : unscramble_addr

	// second word, msb first: t1 t9 t8 t7 t6 t0 t5 t4 t3 t2
	function automatic logic [`TIMER_W-1:0] unscramble_timer(input logic [`INSN_W-1:0] w);
		unscramble_timer = {w[8:5], w[3:0], w[9], w[4]};
	endfunction : unscramble_timer

	always_comb begin
		target_addr = unscramble_addr(operand_word);
		timer_imm   = unscramble_timer(operand_word);
		unique case (opcode_word)
			`OP_JUMP_CARRY:     insn_class = INSN_JUMP_CARRY;
			`OP_JUMP_NO_CARRY:  insn_class = INSN_JUMP_NO_CARRY;
			`OP_JUMP_FLAG:      insn_class = INSN_JUMP_FLAG;
			`OP_JUMP_NO_FLAG:   insn_class = INSN_JUMP_NO_FLAG;
			`OP_CALL:           insn_class = INSN_CALL;
			`OP_RET:            insn_class = INSN_RET;
			`OP_TIMER_RD_LOW:   insn_class = INSN_TIMER_RD_LOW;
			`OP_TIMER_RD_HIGH:  insn_class = INSN_TIMER_RD_HIGH;
			`OP_TIMER_WR_LOW:   insn_class = INSN_TIMER_WR_LOW;
			`OP_TIMER_WR_HIGH:  insn_class = INSN_TIMER_WR_HIGH;
			`OP_TIMER_LOAD_IMM: insn_class = INSN_TIMER_LOAD_IMM;
			default:            insn_class = INSN_NONE;
		endcase
	end

endmodule : insn_decoder

`default_nettype wire

/* branch_call_timer_insn_exec.sv */
// executor for conditional jumps, call/return through one address stack
// register, and the timer nibble and immediate load instructions.
// assumes fetch, pc, accumulator and flags live outside on the same clock;
// every instruction here is presented for one cycle with both words.
`include "insn_exec_params.svh"
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module branch_call_timer_insn_exec
	import insn_exec_pkg::*;
#(
	parameter int PTR_WIDTH = 1  // stack pointer bits
)(
	input  wire logic                   MCLK,            // core clock, 50 MHz
	input  wire logic                   RST_N,           // sync reset, active low
	input  wire logic                   INSN_VALID,      // instruction present
	input  wire logic [`INSN_W-1:0]     INSN_OPCODE,     // first word
	input  wire logic [`INSN_W-1:0]     INSN_OPERAND,    // second word
	input  wire logic [`ADDR_W-1:0]     PC_CURRENT,      // pc of first word
	input  wire logic                   CARRY_FLAG,      // carry flag
	input  wire logic                   STATUS_FLAG,     // status flag
	input  wire logic [`NIB_W-1:0]      ACC_IN,          // accumulator value
	input  wire logic                   TIMER_SLOW_SEL,  // 1: 128 periods
	output logic                        INSN_TAKEN,      // opcode recognised
	output logic                        PC_LOAD,         // load pc pulse
	output logic      [`ADDR_W-1:0]     PC_NEXT,         // new pc
	output logic                        ACC_LOAD,        // load acc pulse
	output logic      [`NIB_W-1:0]      ACC_OUT,         // new acc value
	output logic                        INTERNAL_RESET,  // stack fault pulse
	output logic      [PTR_WIDTH-1:0]   STACK_POINTER,   // stack pointer
	output logic      [`ADDR_W-1:0]     RETURN_ADDR,     // saved pc
	output logic      [`TIMER_W-1:0]    TIMER_VALUE,     // timer register
	output logic                        TIMER_LOADED,    // timer written pulse
	output logic      [`INTERVAL_W-1:0] TIMER_INTERVAL   // interval in periods
);

	if (PTR_WIDTH < 1 || PTR_WIDTH > 8) begin : g_ptr_check
		$error("PTR_WIDTH must be 1 to 8");
	end

	////////////////////////////////////////////////////////////////////////////
	// state

	typedef struct packed {
		logic                    taken;
		logic                    pc_load;
		logic [`ADDR_W-1:0]      pc_value;
		logic                    acc_load;
		logic [`NIB_W-1:0]       acc_value;
		logic                    int_reset;
		logic [PTR_WIDTH-1:0]    stk_ptr;
		logic [`ADDR_W-1:0]      ret_addr;
		logic [`TIMER_W-1:0]     timer;
		logic                    timer_loaded;
		logic [`INTERVAL_W-1:0]  interval;
	} exec_state_t;

	localparam logic [PTR_WIDTH-1:0] PTR_RST = PTR_WIDTH'(`STACK_PTR_RESET);
	localparam logic [PTR_WIDTH-1:0] PTR_ONE = PTR_WIDTH'(1);

	exec_state_t state_reg;
	exec_state_t state_next;

	insn_class_t             insn_class;
	logic [`ADDR_W-1:0]      target_addr;
	logic [`TIMER_W-1:0]     timer_imm;

	////////////////////////////////////////////////////////////////////////////
	// decode

	insn_decoder u_decoder (
		.opcode_word  (INSN_OPCODE),
		.operand_word (INSN_OPERAND),
		.insn_class   (insn_class),
		.target_addr  (target_addr),
		.timer_imm    (timer_imm)
	);

	// pc of the word after a two-word instruction, wraps inside the page
	function automatic logic [`ADDR_W-1:0] skip_pc(input logic [`ADDR_W-1:0] pc);
		skip_pc = pc + `PC_STEP_TWO_WORD;
	endfunction : skip_pc

	function automatic logic [`INTERVAL_W-1:0] interval_of(
		input logic [`TIMER_W-1:0] t,
		input logic                slow
	);
		logic [`INTERVAL_W-1:0] count;
		count = `INTERVAL_W'(t) + `INTERVAL_W'(1);
		interval_of = slow ? `INTERVAL_W'(count * `TIMER_SCALE_SLOW)
		                   : `INTERVAL_W'(count * `TIMER_SCALE_FAST);
	endfunction : interval_of

	////////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		logic                  ptr_carry;
		logic                  ptr_borrow;
		logic [PTR_WIDTH:0]    ptr_inc;
		logic [PTR_WIDTH:0]    ptr_dec;
		ptr_inc    = {1'b0, state_reg.stk_ptr} + {1'b0, PTR_ONE};
		ptr_dec    = {1'b0, state_reg.stk_ptr} - {1'b0, PTR_ONE};
		ptr_carry  = ptr_inc[PTR_WIDTH];
		ptr_borrow = ptr_dec[PTR_WIDTH];

		state_next              = state_reg;
		state_next.taken        = 1'b0;
		state_next.pc_load      = 1'b0;
		state_next.acc_load     = 1'b0;
		state_next.int_reset    = 1'b0;
		state_next.timer_loaded = 1'b0;

		if (INSN_VALID && insn_class != INSN_NONE) begin
			state_next.taken = 1'b1;
		end

		// flags are inputs only; nothing here can write them
		if (INSN_VALID) begin
			unique case (insn_class)
				INSN_JUMP_CARRY: begin
					state_next.pc_load  = 1'b1;
					state_next.pc_value = CARRY_FLAG ? target_addr
					                                 : skip_pc(PC_CURRENT);
				end
				INSN_JUMP_NO_CARRY: begin
					state_next.pc_load  = 1'b1;
					state_next.pc_value = !CARRY_FLAG ? target_addr
					                                  : skip_pc(PC_CURRENT);
				end
				INSN_JUMP_FLAG: begin
					state_next.pc_load  = 1'b1;
					state_next.pc_value = STATUS_FLAG ? target_addr
					                                  : skip_pc(PC_CURRENT);
				end
				INSN_JUMP_NO_FLAG: begin
					state_next.pc_load  = 1'b1;
					state_next.pc_value = !STATUS_FLAG ? target_addr
					                                   : skip_pc(PC_CURRENT);
				end
				INSN_CALL: begin
					if (ptr_carry) begin
						// overflow: fault the core, stack back to empty
						state_next.int_reset = 1'b1;
						state_next.stk_ptr   = PTR_RST;
						state_next.ret_addr  = `RET_ADDR_RESET;
					end else begin
						state_next.stk_ptr  = ptr_inc[PTR_WIDTH-1:0];
						state_next.ret_addr = skip_pc(PC_CURRENT);
						state_next.pc_load  = 1'b1;
						state_next.pc_value = target_addr;
					end
				end
				INSN_RET: begin
					if (ptr_borrow) begin
						state_next.int_reset = 1'b1;
						state_next.stk_ptr   = PTR_RST;
						state_next.ret_addr  = `RET_ADDR_RESET;
					end else begin
						state_next.pc_load  = 1'b1;
						state_next.pc_value = state_reg.ret_addr;
						state_next.stk_ptr  = ptr_dec[PTR_WIDTH-1:0];
					end
				end
				INSN_TIMER_RD_LOW: begin
					state_next.acc_load  = 1'b1;
					state_next.acc_value =
						state_reg.timer[`TIMER_LOW_MSB:`TIMER_LOW_LSB];
				end
				INSN_TIMER_RD_HIGH: begin
					state_next.acc_load  = 1'b1;
					state_next.acc_value =
						state_reg.timer[`TIMER_HIGH_MSB:`TIMER_HIGH_LSB];
				end
				INSN_TIMER_WR_LOW: begin
					state_next.timer_loaded = 1'b1;
					state_next.timer[`TIMER_LOW_MSB:`TIMER_LOW_LSB] = ACC_IN;
					state_next.timer[`TIMER_LOW_CLR_BIT] = 1'b0;
				end
				INSN_TIMER_WR_HIGH: begin
					state_next.timer_loaded = 1'b1;
					state_next.timer[`TIMER_HIGH_MSB:`TIMER_HIGH_LSB] = ACC_IN;
					state_next.timer[`TIMER_HIGH_CLR_BIT] = 1'b0;
				end
				INSN_TIMER_LOAD_IMM: begin
					state_next.timer_loaded = 1'b1;
					state_next.timer        = timer_imm;
				end
				INSN_NONE: begin
				end
			endcase
		end

		state_next.interval = interval_of(state_next.timer, TIMER_SLOW_SEL);
	end

	////////////////////////////////////////////////////////////////////////////
	// registers

	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			state_reg <= '{
				taken:        1'b0,
				pc_load:      1'b0,
				pc_value:     `PAGE_FIRST,
				acc_load:     1'b0,
				acc_value:    4'h0,
				int_reset:    1'b0,
				stk_ptr:      PTR_RST,
				ret_addr:     `RET_ADDR_RESET,
				timer:        `TIMER_RESET,
				timer_loaded: 1'b0,
				interval:     `TIMER_SCALE_FAST
			};
		end else begin
			state_reg <= state_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs

	assign INSN_TAKEN     = state_reg.taken;
	assign PC_LOAD        = state_reg.pc_load;
	assign PC_NEXT        = state_reg.pc_value;
	assign ACC_LOAD       = state_reg.acc_load;
	assign ACC_OUT        = state_reg.acc_value;
	assign INTERNAL_RESET = state_reg.int_reset;
	assign STACK_POINTER  = state_reg.stk_ptr;
	assign RETURN_ADDR    = state_reg.ret_addr;
	assign TIMER_VALUE    = state_reg.timer;
	assign TIMER_LOADED   = state_reg.timer_loaded;
	assign TIMER_INTERVAL = state_reg.interval;

endmodule : branch_call_timer_insn_exec

`default_nettype wire

/* insn_exec_assertions.sv */
// checker for the branch, call, return and timer executor.
// assumes it is bound to the executor and sees its ports only.
`include "insn_exec_params.svh"
`default_nettype none

module insn_exec_assertions
	import insn_exec_pkg::*;
#(
	parameter int PTR_WIDTH = 1	// stack pointer bits
)(
	input wire logic			MCLK,		// clock
	input wire logic			RST_N,		// reset
	input wire logic			INSN_VALID,	// valid
	input wire logic [9:0]		INSN_OPCODE,	// word one
	input wire logic [9:0]		INSN_OPERAND,	// word two
	input wire logic [9:0]		PC_CURRENT,	// pc
	input wire logic			CARRY_FLAG,	// carry
	input wire logic			STATUS_FLAG,	// flag
	input wire logic [3:0]		ACC_IN,		// acc in
	input wire logic			TIMER_SLOW_SEL,	// scale
	input wire logic			INSN_TAKEN,	// taken
	input wire logic			PC_LOAD,	// pc load
	input wire logic [9:0]		PC_NEXT,	// new pc
	input wire logic			ACC_LOAD,	// acc load
	input wire logic [3:0]		ACC_OUT,	// acc out
	input wire logic			INTERNAL_RESET,	// fault
	input wire logic [PTR_WIDTH-1:0]	STACK_POINTER,	// stack depth
	input wire logic [9:0]		RETURN_ADDR,	// saved pc
	input wire logic [9:0]		TIMER_VALUE,	// timer
	input wire logic			TIMER_LOADED,	// timer written
	input wire logic [17:0]		TIMER_INTERVAL	// interval
);
	function automatic logic [9:0] addr_of(input logic [9:0] w);
		return {w[9], w[4], w[8:5], w[3:0]};
	endfunction : addr_of

	function automatic logic [9:0] tmr_of(input logic [9:0] w);
		return {w[8:5], w[3:0], w[9], w[4]};
	endfunction : tmr_of

	logic	jmp, hit, call, ret, full, empty;
	assign jmp = INSN_VALID && (INSN_OPCODE inside {`OP_JUMP_CARRY, `OP_JUMP_NO_CARRY,
		`OP_JUMP_FLAG, `OP_JUMP_NO_FLAG});
	// bit 6 picks flag over carry, bit 5 inverts the test
	assign hit = (INSN_OPCODE[6] ? STATUS_FLAG : CARRY_FLAG) ^ INSN_OPCODE[5];
	assign call = INSN_VALID && INSN_OPCODE == `OP_CALL;
	assign ret = INSN_VALID && INSN_OPCODE == `OP_RET;
	assign full = &STACK_POINTER;
	assign empty = STACK_POINTER == '0;

	default clocking cb @(posedge MCLK); endclocking
	default disable iff (!RST_N);

	a_jump_taken:
		assert property (jmp && hit |=> PC_LOAD && PC_NEXT == addr_of($past(INSN_OPERAND)))
		else $error("jump target wrong");
	a_jump_skip:
		assert property (jmp && !hit |=> PC_LOAD && PC_NEXT == $past(PC_CURRENT) + 10'h002)
		else $error("jump skip wrong");
	a_call_push:
		assert property (call && !full |=> PC_LOAD && STACK_POINTER == $past(STACK_POINTER) + 1'b1
			&& RETURN_ADDR == $past(PC_CURRENT) + 10'h002
			&& PC_NEXT == addr_of($past(INSN_OPERAND)))
		else $error("call push wrong");
	a_call_over:
		assert property (call && full |=> INTERNAL_RESET && !PC_LOAD && empty)
		else $error("call overflow missed");
	a_ret_pop:
		assert property (ret && !empty |=> PC_LOAD && PC_NEXT == $past(RETURN_ADDR)
			&& STACK_POINTER == $past(STACK_POINTER) - 1'b1)
		else $error("return pop wrong");
	a_ret_under:
		assert property (ret && empty |=> INTERNAL_RESET && !PC_LOAD)
		else $error("return underflow missed");
	a_wr_high:
		assert property (INSN_VALID && INSN_OPCODE == `OP_TIMER_WR_HIGH |=> TIMER_LOADED
			&& TIMER_VALUE[9:6] == $past(ACC_IN) && !TIMER_VALUE[1])
		else $error("high nibble write wrong");
	a_wr_low:
		assert property (INSN_VALID && INSN_OPCODE == `OP_TIMER_WR_LOW |=> TIMER_LOADED
			&& TIMER_VALUE[5:2] == $past(ACC_IN) && !TIMER_VALUE[0])
		else $error("low nibble write wrong");
	a_timer_imm:
		assert property (INSN_VALID && INSN_OPCODE == `OP_TIMER_LOAD_IMM
			|=> TIMER_LOADED && TIMER_VALUE == tmr_of($past(INSN_OPERAND)))
		else $error("immediate timer load wrong");
	a_interval:
		assert property (TIMER_LOADED |-> TIMER_INTERVAL == ({8'h00, TIMER_VALUE} + 18'h0_0001)
			* ($past(TIMER_SLOW_SEL) ? `TIMER_SCALE_SLOW : `TIMER_SCALE_FAST))
		else $error("timer interval wrong");
	a_rd_high:
		assert property (INSN_VALID && INSN_OPCODE == `OP_TIMER_RD_HIGH |=> ACC_LOAD
			&& ACC_OUT == $past(TIMER_VALUE[9:6]))
		else $error("high nibble read wrong");
	a_rd_low:
		assert property (INSN_VALID && INSN_OPCODE == `OP_TIMER_RD_LOW |=> ACC_LOAD
			&& ACC_OUT == $past(TIMER_VALUE[5:2]))
		else $error("low nibble read wrong");
endmodule : insn_exec_assertions

bind branch_call_timer_insn_exec insn_exec_assertions #(.PTR_WIDTH(PTR_WIDTH)) u_chk (
	.MCLK(MCLK), .RST_N(RST_N), .INSN_VALID(INSN_VALID), .INSN_OPCODE(INSN_OPCODE),
	.INSN_OPERAND(INSN_OPERAND), .PC_CURRENT(PC_CURRENT), .CARRY_FLAG(CARRY_FLAG),
	.STATUS_FLAG(STATUS_FLAG), .ACC_IN(ACC_IN), .TIMER_SLOW_SEL(TIMER_SLOW_SEL),
	.INSN_TAKEN(INSN_TAKEN), .PC_LOAD(PC_LOAD), .PC_NEXT(PC_NEXT), .ACC_LOAD(ACC_LOAD),
	.ACC_OUT(ACC_OUT), .INTERNAL_RESET(INTERNAL_RESET), .STACK_POINTER(STACK_POINTER),
	.RETURN_ADDR(RETURN_ADDR), .TIMER_VALUE(TIMER_VALUE), .TIMER_LOADED(TIMER_LOADED),
	.TIMER_INTERVAL(TIMER_INTERVAL)
);

`default_nettype wire

/* test_branch_call_timer_insn_exec.sv */
// self-checking bench for the branch, call, return and timer executor.
// assumes the package, the executor and the bound checker are compiled first.
`include "insn_exec_params.svh"
`default_nettype none

module test_branch_call_timer_insn_exec;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int PTRW = 2;
	logic	MCLK = 1'b0, RST_N = 1'b0, INSN_VALID = 1'b0, CARRY_FLAG = 1'b0;
	logic	STATUS_FLAG = 1'b0, TIMER_SLOW_SEL = 1'b0;
	logic	INSN_TAKEN, PC_LOAD, ACC_LOAD, INTERNAL_RESET, TIMER_LOADED;
	logic [9:0]	INSN_OPCODE = '0, INSN_OPERAND = '0, PC_CURRENT = '0;
	logic [9:0]	PC_NEXT, RETURN_ADDR, TIMER_VALUE;
	logic [3:0]	ACC_IN = '0, ACC_OUT;
	logic [PTRW-1:0]	STACK_POINTER, m_ptr = '0;
	logic [17:0]	TIMER_INTERVAL;
	logic [9:0]	m_pc = '0, m_ret = '0, m_tmr = '0;
	logic [3:0]	m_acc = '0;
	logic [15:0]	seed = 16'h0050;
	int		n_errors = 0, n_checks = 0, cycles = 0;
	logic [9:0]	ops [12] = '{`OP_JUMP_CARRY, `OP_JUMP_NO_CARRY, `OP_JUMP_FLAG, `OP_JUMP_NO_FLAG,
		`OP_CALL, `OP_RET, `OP_TIMER_RD_LOW, `OP_TIMER_RD_HIGH, `OP_TIMER_WR_LOW,
		`OP_TIMER_WR_HIGH, `OP_TIMER_LOAD_IMM, 10'h2A5};

	always #10 MCLK = ~MCLK;

	branch_call_timer_insn_exec #(.PTR_WIDTH(PTRW)) u_dut (
		.MCLK(MCLK), .RST_N(RST_N), .INSN_VALID(INSN_VALID), .INSN_OPCODE(INSN_OPCODE),
		.INSN_OPERAND(INSN_OPERAND), .PC_CURRENT(PC_CURRENT), .CARRY_FLAG(CARRY_FLAG),
		.STATUS_FLAG(STATUS_FLAG), .ACC_IN(ACC_IN), .TIMER_SLOW_SEL(TIMER_SLOW_SEL),
		.INSN_TAKEN(INSN_TAKEN), .PC_LOAD(PC_LOAD), .PC_NEXT(PC_NEXT), .ACC_LOAD(ACC_LOAD),
		.ACC_OUT(ACC_OUT), .INTERNAL_RESET(INTERNAL_RESET), .STACK_POINTER(STACK_POINTER),
		.RETURN_ADDR(RETURN_ADDR), .TIMER_VALUE(TIMER_VALUE), .TIMER_LOADED(TIMER_LOADED),
		.TIMER_INTERVAL(TIMER_INTERVAL));

	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr

	function automatic logic [9:0] addr_of(input logic [9:0] w);
		return {w[9], w[4], w[8:5], w[3:0]};
	endfunction : addr_of

	task automatic chk(input logic [17:0] got, input logic [17:0] exp);
		n_checks++;
		if (got !== exp) begin
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
			n_errors++;
		end
	endtask : chk

	task automatic report_and_stop();
		$display("checks=%0d errors=%0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : report_and_stop

	always @(posedge MCLK) begin
		cycles++;
		if (cycles == 5000) begin
			n_errors++;
			report_and_stop();
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// one instruction for one cycle, model updated, outputs checked after the edge
	task automatic exec(input logic [9:0] op, input logic [9:0] wd, input logic cf,
		input logic fl);
		logic [9:0]	pc;
		logic		taken, ld, al, ir, tl;
		seed = lfsr(seed);
		pc = seed[9:0];
		{taken, ld, al, ir, tl} = 5'b1_0000;
		case (op)
			`OP_JUMP_CARRY, `OP_JUMP_NO_CARRY, `OP_JUMP_FLAG, `OP_JUMP_NO_FLAG: begin
				ld = 1'b1;
				m_pc = ((op[6] ? fl : cf) ^ op[5]) ? addr_of(wd) : pc + 10'h002;
			end
			`OP_CALL: if (m_ptr == '1) {ir, m_ptr, m_ret} = {1'b1, 12'h000};
				else {ld, m_ptr, m_ret, m_pc} = {1'b1, m_ptr + 2'd1, pc + 10'h002, addr_of(wd)};
			`OP_RET: if (m_ptr == '0) {ir, m_ret} = {1'b1, 10'h000};
				else {ld, m_pc, m_ptr} = {1'b1, m_ret, m_ptr - 2'd1};
			`OP_TIMER_RD_HIGH: {al, m_acc} = {1'b1, m_tmr[9:6]};
			`OP_TIMER_RD_LOW: {al, m_acc} = {1'b1, m_tmr[5:2]};
			`OP_TIMER_WR_HIGH: {tl, m_tmr} = {1'b1, seed[13:10], m_tmr[5:2], 1'b0, m_tmr[0]};
			`OP_TIMER_WR_LOW: {tl, m_tmr} = {1'b1, m_tmr[9:6], seed[13:10], m_tmr[1], 1'b0};
			`OP_TIMER_LOAD_IMM: {tl, m_tmr} = {1'b1, wd[8:5], wd[3:0], wd[9], wd[4]};
			default: taken = 1'b0;
		endcase
		{INSN_OPCODE, INSN_OPERAND, PC_CURRENT} = {op, wd, pc};
		{CARRY_FLAG, STATUS_FLAG, ACC_IN, TIMER_SLOW_SEL} = {cf, fl, seed[13:10], seed[15]};
		INSN_VALID = 1'b1;
		@(posedge MCLK);
		#1;
		chk(18'({PC_LOAD, ACC_LOAD, TIMER_LOADED}), 18'({ld, al, tl}));
		chk(18'(INTERNAL_RESET), 18'(ir));
		chk(18'(INSN_TAKEN), 18'(taken));
		chk(18'({ACC_OUT, PC_NEXT}), 18'({m_acc, m_pc}));
		chk(18'({STACK_POINTER, RETURN_ADDR}), 18'({m_ptr, m_ret}));
		chk(18'(TIMER_VALUE), 18'(m_tmr));
		chk(TIMER_INTERVAL, (18'(m_tmr) + 18'h0_0001)
			* (seed[15] ? `TIMER_SCALE_SLOW : `TIMER_SCALE_FAST));
	endtask : exec

	task automatic idle();
		INSN_VALID = 1'b0;
		@(posedge MCLK);
		#1;
		chk(18'({INSN_TAKEN, PC_LOAD, ACC_LOAD, INTERNAL_RESET, TIMER_LOADED}), 18'h0_0000);
	endtask : idle

	initial begin
		repeat (8) @(posedge MCLK);
		#1;
		chk(TIMER_INTERVAL, `TIMER_SCALE_FAST);
		chk(18'({STACK_POINTER, RETURN_ADDR}), 18'h0_0000);
		chk(18'({PC_NEXT, TIMER_VALUE[7:0]}), 18'h0_0000);
		chk(18'({TIMER_VALUE, ACC_OUT, INSN_TAKEN, PC_LOAD, ACC_LOAD, INTERNAL_RESET}), 18'h0);
		chk(18'(TIMER_LOADED), 18'h0_0000);
		RST_N = 1'b1;
		for (int i = 0; i < 16; i++) begin
			exec(ops[i % 4], i[2] ? 10'h3FF : 10'h155, i[2], i[3]);
		end
		repeat (7) exec(`OP_CALL, seed[9:0], 1'b1, 1'b0);
		repeat (4) exec(`OP_RET, seed[9:0], 1'b0, 1'b1);
		for (int i = 6; i < 11; i++) exec(ops[i], 10'h3FF, 1'b0, 1'b0);
		repeat (400) begin
			seed = lfsr(seed);
			if (seed[0]) idle();
			exec(ops[seed[15:4] % 12], {seed[3:0], seed[15:10]}, seed[1], seed[2]);
		end
		idle();
		report_and_stop();
	end
endmodule : test_branch_call_timer_insn_exec

`default_nettype wire
